//--- rtl/dsa_pkg.sv
// package: constants and carriers for the data space access unit
package dsa_pkg;
   localparam int AW = 16;
   localparam int DW = 16;
   localparam int NEAR_W = 13;
   localparam logic [15:0] CTRL_TOP = 16'h07ff;
   localparam logic [15:0] NEAR_TOP = 16'h1fff;
   localparam logic [15:0] RAM_TOP_DEF = 16'h77ff;
   localparam logic [15:0] Y_BASE_DEF = 16'h4800;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam int WIN_BIT = 15;

   typedef enum logic [1:0] {
      DSA_MODE_DIRECT,
      DSA_MODE_NEAR,
      DSA_MODE_INDIRECT
   } dsa_amode_e;

   typedef enum logic [1:0] {
      DSA_LOAD_PLAIN,
      DSA_LOAD_SIGN,
      DSA_LOAD_ZERO
   } dsa_ext_e;

   typedef struct packed {
      logic req;
      logic byte_op;
      dsa_amode_e mode;
      logic [15:0] direct;
      logic [15:0] source_pointer_reg;
      logic post_inc;
      logic modulo_en;
      logic [15:0] mod_start;
      logic [15:0] mod_end;
      logic bitrev_en;
      logic [15:0] bitrev_mod;
   } dsa_agu_req_s;

   typedef struct packed {
      logic [15:0] byte_pointer;
      logic [15:0] next_pointer;
      logic misaligned;
   } dsa_agu_rsp_s;
endpackage

//--- rtl/dsa_ram.sv
// byte-laned data memory with registered dual read ports
`timescale 1ns/100ps
`default_nettype none
module dsa_ram #(
   parameter int WORDS = 15360,
   parameter int IW = 14
) (
   // clock
   input wire logic mclk,
   // x read port
   input wire logic [IW-1:0] xr_idx,
   output logic [15:0] xr_data,
   // y read port
   input wire logic [IW-1:0] yr_idx,
   output logic [15:0] yr_data,
   // write port
   input wire logic [IW-1:0] w_idx,
   input wire logic [1:0] w_lane,
   input wire logic [15:0] w_data
);
   logic [7:0] lo_mem [WORDS];
   logic [7:0] hi_mem [WORDS];

   // separate byte strobes, shared word decode
   always_ff @(posedge mclk)
   begin
      if (w_lane[0])
         lo_mem[w_idx] <= w_data[7:0];
      if (w_lane[1])
         hi_mem[w_idx] <= w_data[15:8];
      xr_data <= {hi_mem[xr_idx], lo_mem[xr_idx]};
      yr_data <= {hi_mem[yr_idx], lo_mem[yr_idx]};
   end
endmodule
`default_nettype wire

//--- rtl/dsa_unit.sv
// data space access unit: address units, decode, alignment, byte lanes
`timescale 1ns/100ps
`default_nettype none
module dsa_unit
   import dsa_pkg::*;
#(
   parameter logic [15:0] RAM_TOP = dsa_pkg::RAM_TOP_DEF,
   parameter logic [15:0] Y_BASE = dsa_pkg::Y_BASE_DEF,
   parameter int RAM_WORDS = 15360,
   parameter int IW = 14
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // x read request
   input wire dsa_pkg::dsa_agu_req_s xr_req,
   input wire dsa_pkg::dsa_ext_e xr_ext,
   input wire logic [15:0] xr_wreg,
   // y read request (dual fetch)
   input wire dsa_pkg::dsa_agu_req_s yr_req,
   input wire logic dual_fetch_dsp_ops,
   // write request
   input wire dsa_pkg::dsa_agu_req_s w_req,
   input wire logic [15:0] w_data,
   // control register region
   input wire logic [15:0] ctrl_rdata,
   input wire logic ctrl_hit,
   output logic ctrl_rd,
   output logic ctrl_wr,
   output logic [1:0] ctrl_lane,
   output logic [15:0] ctrl_addr,
   output logic [15:0] ctrl_wdata,
   // program window
   input wire logic [15:0] program_window_rdata,
   output logic program_window_rd,
   output logic [14:0] program_window_addr,
   // pointer updates
   output logic [15:0] xr_ptr_upd,
   output logic [15:0] yr_ptr_upd,
   output logic [15:0] w_ptr_upd,
   // results
   output logic [15:0] xr_result_r,
   output logic xr_valid_r,
   output logic [15:0] yr_result_r,
   output logic yr_valid_r,
   output logic trap_r
);
   // bit order swap for reverse-carry addressing
   function automatic logic [AW-1:0] rev16(input logic [AW-1:0] v);
      logic [AW-1:0] r;
      r = 16'h0000;
      for (int i = 0; i < AW; i++)
         r[i] = v[AW-1-i];
      return r;
   endfunction

   function automatic dsa_agu_rsp_s address_calc_unit(input dsa_agu_req_s q,
                                        input logic allow_rev);
      logic [15:0] ea;
      logic [15:0] step;
      logic [15:0] nx;
      dsa_agu_rsp_s r;
      ea = 16'h0000;
      step = q.byte_op ? STEP_BYTE : STEP_WORD;
      case (q.mode)
         DSA_MODE_NEAR:
            ea = {{(AW-NEAR_W){1'b0}}, q.direct[NEAR_W-1:0]};
         DSA_MODE_DIRECT:
            ea = q.direct;
         default:
            ea = q.source_pointer_reg;
      endcase
      nx = ea + step;
      if (q.modulo_en && ea >= q.mod_end)
         nx = q.mod_start;
      if (allow_rev && q.bitrev_en)
         nx = rev16(rev16(ea) + rev16(q.bitrev_mod));
      r.byte_pointer = ea;
      r.next_pointer = q.post_inc ? nx : ea;
      r.misaligned = q.req && !q.byte_op && ea[0];
      return r;
   endfunction

   function automatic logic in_ctrl(input logic [15:0] a);
      return a <= CTRL_TOP;
   endfunction

   function automatic logic in_ram(input logic [15:0] a);
      return !a[WIN_BIT] && a > CTRL_TOP && a <= RAM_TOP;
   endfunction

   function automatic logic [IW-1:0] ram_idx(input logic [15:0] a);
      logic [15:0] off;
      off = a - CTRL_TOP - 16'h0001;
      return off[IW:1];
   endfunction

   // separate address units for x read, y read and write
   dsa_agu_rsp_s xa;
   dsa_agu_rsp_s ya;
   dsa_agu_rsp_s wa;
   assign xa = address_calc_unit(xr_req, 1'b0);
   assign ya = address_calc_unit(yr_req, 1'b0);
   assign wa = address_calc_unit(w_req, 1'b1); // bit-reverse on write only

   assign xr_ptr_upd = xa.next_pointer;
   assign yr_ptr_upd = ya.next_pointer;
   assign w_ptr_upd = wa.next_pointer;

   // y read only for dual fetch ops inside y space
   wire y_go;
   assign y_go = yr_req.req && dual_fetch_dsp_ops &&
      ya.byte_pointer >= Y_BASE && ya.byte_pointer <= RAM_TOP &&
      !ya.misaligned;

   // writes: combined space, fixed boundary, suppressed if misaligned
   wire w_go;
   wire [1:0] w_lane;
   wire [15:0] w_lanes_data;
   assign w_go = w_req.req && !wa.misaligned;
   assign w_lane = !w_req.byte_op ? 2'b11 :
      (wa.byte_pointer[0] ? 2'b10 : 2'b01);
   assign w_lanes_data = w_req.byte_op ?
      {w_data[7:0], w_data[7:0]} : w_data;

   wire w_ram;
   assign w_ram = w_go && in_ram(wa.byte_pointer);
   assign ctrl_wr = w_go && in_ctrl(wa.byte_pointer);
   assign ctrl_lane = w_lane;
   assign ctrl_wdata = w_lanes_data;
   assign ctrl_rd = xr_req.req && in_ctrl(xa.byte_pointer);
   assign ctrl_addr = ctrl_wr ? {wa.byte_pointer[15:1], 1'b0} :
      {xa.byte_pointer[15:1], 1'b0};
   assign program_window_rd = xr_req.req && xa.byte_pointer[WIN_BIT];
   assign program_window_addr = xa.byte_pointer[14:0];

   logic [15:0] xr_mem;
   logic [15:0] yr_mem;
   dsa_ram #(
      .WORDS(RAM_WORDS),
      .IW(IW)
   ) u_ram (
      .mclk(mclk),
      .xr_idx(ram_idx(xa.byte_pointer)),
      .xr_data(xr_mem),
      .yr_idx(ram_idx(ya.byte_pointer)),
      .yr_data(yr_mem),
      .w_idx(ram_idx(wa.byte_pointer)),
      .w_lane(w_ram ? w_lane : 2'b00),
      .w_data(w_lanes_data)
   );

   // registered request context for the read return cycle
   typedef enum logic [1:0] {
      DSA_SRC_ZERO,
      DSA_SRC_RAM,
      DSA_SRC_CTRL,
      DSA_SRC_WIN
   } dsa_src_e;

   dsa_src_e src_r;
   logic x_pend_r;
   logic y_pend_r;
   logic lane_hi_r;
   logic byte_r;
   dsa_ext_e ext_r;
   logic [15:0] wreg_r;
   logic [15:0] ctrl_cap_r;
   logic [15:0] win_cap_r;
   logic trap_pend_r;

   wire dsa_src_e src_nxt;
   assign src_nxt =
      xa.byte_pointer[WIN_BIT] ? DSA_SRC_WIN :
      in_ctrl(xa.byte_pointer) ? (ctrl_hit ? DSA_SRC_CTRL : DSA_SRC_ZERO) :
      in_ram(xa.byte_pointer) ? DSA_SRC_RAM : DSA_SRC_ZERO;

   // misaligned events from any unit
   wire mis_any;
   assign mis_any = xa.misaligned || w_req.req && wa.misaligned ||
      yr_req.req && ya.misaligned;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         x_pend_r <= 1'b0;
         y_pend_r <= 1'b0;
         src_r <= DSA_SRC_ZERO;
         lane_hi_r <= 1'b0;
         byte_r <= 1'b0;
         ext_r <= DSA_LOAD_PLAIN;
         wreg_r <= 16'h0000;
         ctrl_cap_r <= 16'h0000;
         win_cap_r <= 16'h0000;
         trap_pend_r <= 1'b0;
      end
      else
      begin
         x_pend_r <= xr_req.req; // misaligned read still completes
         y_pend_r <= y_go;
         src_r <= src_nxt;
         lane_hi_r <= xa.byte_pointer[0];
         byte_r <= xr_req.byte_op;
         ext_r <= xr_ext;
         wreg_r <= xr_wreg;
         ctrl_cap_r <= ctrl_rdata;
         win_cap_r <= program_window_rdata;
         trap_pend_r <= mis_any;
      end
   end

   // x read bus: combined space, control registers and program window
   wire [15:0] x_word;
   assign x_word = src_r == DSA_SRC_RAM ? xr_mem :
      src_r == DSA_SRC_CTRL ? ctrl_cap_r :
      src_r == DSA_SRC_WIN ? win_cap_r : 16'h0000;

   wire [7:0] x_byte;
   assign x_byte = lane_hi_r ? x_word[15:8] : x_word[7:0];

   wire [15:0] x_fmt;
   assign x_fmt = !byte_r ? x_word :
      ext_r == DSA_LOAD_SIGN ? {{8{x_byte[7]}}, x_byte} :
      ext_r == DSA_LOAD_ZERO ? {8'h00, x_byte} :
      {wreg_r[15:8], x_byte};

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         xr_result_r <= 16'h0000;
         xr_valid_r <= 1'b0;
         yr_result_r <= 16'h0000;
         yr_valid_r <= 1'b0;
         trap_r <= 1'b0;
      end
      else
      begin
         xr_result_r <= x_pend_r ? x_fmt : xr_result_r;
         xr_valid_r <= x_pend_r;
         yr_result_r <= y_pend_r ? yr_mem : yr_result_r;
         yr_valid_r <= y_pend_r;
         trap_r <= trap_pend_r; // trap in the same cycle as the read result
      end
   end

   a_word_odd_trap: assert property (
      @(posedge mclk) disable iff (rst)
      (xr_req.req && !xr_req.byte_op && xa.byte_pointer[0]) |-> ##2 trap_r)
      else $error("odd word read did not trap");

   a_odd_write_block: assert property (
      @(posedge mclk) disable iff (rst)
      (w_req.req && !w_req.byte_op && wa.byte_pointer[0]) |->
      !ctrl_wr && !w_ram)
      else $error("misaligned write not suppressed");

   a_write_trap: assert property (
      @(posedge mclk) disable iff (rst)
      (w_req.req && !w_req.byte_op && wa.byte_pointer[0]) |-> ##2 trap_r)
      else $error("odd word write did not trap");

   a_read_completes: assert property (
      @(posedge mclk) disable iff (rst)
      xr_req.req |-> ##2 xr_valid_r)
      else $error("read did not complete");

   a_byte_step: assert property (
      @(posedge mclk) disable iff (rst)
      (xr_req.post_inc && xr_req.byte_op && !xr_req.modulo_en) |->
      xr_ptr_upd == xa.byte_pointer + STEP_BYTE)
      else $error("byte step wrong");

   a_word_step: assert property (
      @(posedge mclk) disable iff (rst)
      (w_req.post_inc && !w_req.byte_op && !w_req.modulo_en &&
      !w_req.bitrev_en) |-> w_ptr_upd == wa.byte_pointer + STEP_WORD)
      else $error("word step wrong");

   a_window_zero: assert property (
      @(posedge mclk) disable iff (rst)
      (xr_req.req && !xa.byte_pointer[WIN_BIT] &&
      xa.byte_pointer > RAM_TOP) |-> ##2 (xr_valid_r && xr_result_r ==
      ($past(xr_req.byte_op, 2) && $past(xr_ext, 2) == DSA_LOAD_PLAIN ?
      {$past(xr_wreg, 2)} & 16'hff00 : 16'h0000)))
      else $error("unimplemented read not zero");

   a_byte_upper_kept: assert property (
      @(posedge mclk) disable iff (rst)
      (xr_req.req && xr_req.byte_op && xr_ext == DSA_LOAD_PLAIN) |->
      ##2 xr_result_r[15:8] == $past(xr_wreg[15:8], 2))
      else $error("byte load changed upper byte");

   a_zero_ext: assert property (
      @(posedge mclk) disable iff (rst)
      (xr_req.req && xr_req.byte_op && xr_ext == DSA_LOAD_ZERO) |->
      ##2 xr_result_r[15:8] == 8'h00)
      else $error("zero extension left upper bits");

   a_y_only_dual: assert property (
      @(posedge mclk) disable iff (rst)
      yr_valid_r |-> $past(dual_fetch_dsp_ops, 2))
      else $error("y read without dual fetch op");

   a_y_refused: assert property (
      @(posedge mclk) disable iff (rst)
      (yr_req.req && !dual_fetch_dsp_ops) |-> ##2 !yr_valid_r)
      else $error("y read completed without dual fetch op");

   a_window_route: assert property (
      @(posedge mclk) disable iff (rst)
      (xr_req.req && xa.byte_pointer[WIN_BIT]) |->
      program_window_rd && !ctrl_rd)
      else $error("upper half not routed to window");

   a_byte_lane: assert property (
      @(posedge mclk) disable iff (rst)
      ((ctrl_wr || w_ram) && w_req.byte_op) |->
      $onehot(ctrl_lane) && ctrl_lane[1] == wa.byte_pointer[0])
      else $error("byte write strobe on wrong half");

   a_ctrl_region: assert property (
      @(posedge mclk) disable iff (rst)
      (xr_req.req && xa.byte_pointer > CTRL_TOP) |-> !ctrl_rd)
      else $error("control strobe outside control region");
endmodule
`default_nettype wire

//--- tb/dsa_far_model.sv
// far side model: control registers and program window
`timescale 1ns/100ps
`default_nettype none
module dsa_far_model (
   // clock
   input wire logic mclk,
   // control register region
   input wire logic ctrl_rd,
   input wire logic ctrl_wr,
   input wire logic [1:0] ctrl_lane,
   input wire logic [15:0] ctrl_addr,
   input wire logic [15:0] ctrl_wdata,
   output logic [15:0] ctrl_rdata,
   output logic ctrl_hit,
   // program window
   input wire logic program_window_rd,
   input wire logic [14:0] program_window_addr,
   output logic [15:0] program_window_rdata
);
   logic [15:0] regs_r [4];
   logic [15:0] idle_r = 16'h0000;
   wire logic sel = ctrl_addr[15:3] == 13'h0004;
   wire logic [7:0] pa = program_window_addr[8:1];
   // four live words at 0x0020, the rest of the region is unused
   assign ctrl_hit = sel;
   assign ctrl_rdata = ctrl_rd ? regs_r[ctrl_addr[2:1]] : idle_r;
   assign program_window_rdata = program_window_rd ? {~pa, pa} : ~idle_r;
   always @(posedge mclk)
   begin
      idle_r <= idle_r + 16'h1357;
      if (ctrl_wr && sel && ctrl_lane[0])
         regs_r[ctrl_addr[2:1]][7:0] <= ctrl_wdata[7:0];
      if (ctrl_wr && sel && ctrl_lane[1])
         regs_r[ctrl_addr[2:1]][15:8] <= ctrl_wdata[15:8];
   end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the data space access unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import dsa_pkg::*;
   typedef struct packed {logic [15:0] v; logic t;} dsa_note_s;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   dsa_agu_req_s xr_req = '0;
   dsa_agu_req_s yr_req = '0;
   dsa_agu_req_s w_req = '0;
   dsa_ext_e xr_ext = DSA_LOAD_PLAIN;
   logic [15:0] xr_wreg = 16'h0000;
   logic [15:0] w_data = 16'h0000;
   logic dual = 1'b0;
   logic [15:0] c_rdata, c_addr, c_wdata, p_rdata, xu, yu, wu, xres, yres;
   logic c_hit, c_rd, c_wr, p_rd, xv, yv, trap_r;
   logic [1:0] c_lane;
   logic [14:0] p_addr;
   int num_errors = 0;
   int total_checks = 0;
   int n_trap = 0;
   int n_trap_exp = 0;
   dsa_note_s xq[$];
   dsa_note_s cur;
   dsa_agu_req_s pr;
   logic [15:0] yq[$];
   logic [15:0] mem [int];
   logic [15:0] ra [8];
   logic [31:0] seed = 32'd66465;
   always #2.5 mclk = ~mclk;
   dsa_unit dut (.mclk(mclk), .rst(rst), .xr_req(xr_req), .xr_ext(xr_ext),
      .xr_wreg(xr_wreg), .yr_req(yr_req), .dual_fetch_dsp_ops(dual),
      .w_req(w_req), .w_data(w_data), .ctrl_rdata(c_rdata),
      .ctrl_hit(c_hit), .ctrl_rd(c_rd), .ctrl_wr(c_wr), .ctrl_lane(c_lane),
      .ctrl_addr(c_addr), .ctrl_wdata(c_wdata),
      .program_window_rdata(p_rdata), .program_window_rd(p_rd),
      .program_window_addr(p_addr), .xr_ptr_upd(xu), .yr_ptr_upd(yu),
      .w_ptr_upd(wu), .xr_result_r(xres), .xr_valid_r(xv),
      .yr_result_r(yres), .yr_valid_r(yv), .trap_r(trap_r));
   dsa_far_model far (.mclk(mclk), .ctrl_rd(c_rd), .ctrl_wr(c_wr),
      .ctrl_lane(c_lane), .ctrl_addr(c_addr), .ctrl_wdata(c_wdata),
      .ctrl_rdata(c_rdata), .ctrl_hit(c_hit), .program_window_rd(p_rd),
      .program_window_addr(p_addr), .program_window_rdata(p_rdata));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] got, exp, input string m);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   function automatic dsa_agu_req_s mk(input logic [15:0] a,
      input logic bo, input dsa_amode_e md);
      dsa_agu_req_s r;
      r = '0;
      r.req = 1'b1;
      r.byte_op = bo;
      r.mode = md;
      r.direct = (md == DSA_MODE_NEAR) ? {3'b111, a[12:0]} : a;
      r.source_pointer_reg = a;
      r.post_inc = 1'b1;
      return r;
   endfunction
   function automatic logic [15:0] exp_rd(input logic [15:0] a,
      input logic bo, input dsa_ext_e e, input logic [15:0] wr);
      logic [15:0] w;
      logic [7:0] b;
      if (a[15])
         w = {~a[8:1], a[8:1]};
      else if (a > RAM_TOP_DEF || (a <= CTRL_TOP && a[15:3] != 13'h0004))
         w = 16'h0000;
      else
         w = mem[a[15:1]];
      b = a[0] ? w[15:8] : w[7:0];
      if (!bo)
         return w;
      if (e == DSA_LOAD_SIGN)
         return {{8{b[7]}}, b};
      if (e == DSA_LOAD_ZERO)
         return {8'h00, b};
      return {wr[15:8], b};
   endfunction
   task automatic xrd(input logic [15:0] a, input logic bo,
      input dsa_ext_e e, input dsa_amode_e md);
      @(posedge mclk);
      seed = lfsr(seed);
      xr_req <= mk(a, bo, md);
      xr_ext <= e;
      xr_wreg <= seed[15:0];
      xq.push_back({exp_rd(a, bo, e, seed[15:0]), !bo && a[0]});
      n_trap_exp += (!bo && a[0]) ? 1 : 0;
      #1;
      if (md == DSA_MODE_INDIRECT)
         chk(xu, a + (bo ? STEP_BYTE : STEP_WORD), "pointer step");
      @(posedge mclk);
      xr_req.req <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic bo,
      input logic [15:0] d);
      @(posedge mclk);
      w_req <= mk(a, bo, DSA_MODE_DIRECT);
      w_data <= bo ? {d[7:0], d[7:0]} : d;
      if (!bo && a[0])
         n_trap_exp++;
      else if (!bo)
         mem[a[15:1]] = d;
      else if (a[0])
         mem[a[15:1]][15:8] = d[7:0];
      else
         mem[a[15:1]][7:0] = d[7:0];
      #1;
      chk(wu, a + (bo ? STEP_BYTE : STEP_WORD), "write step");
      @(posedge mclk);
      w_req.req <= 1'b0;
   endtask
   task automatic ydual(input logic [15:0] xa, ya, input logic df);
      @(posedge mclk);
      xr_req <= mk(xa, 1'b0, DSA_MODE_DIRECT);
      yr_req <= mk(ya, 1'b0, DSA_MODE_INDIRECT);
      dual <= df;
      xq.push_back({mem[xa[15:1]], 1'b0});
      if (df)
         yq.push_back(mem[ya[15:1]]);
      #1;
      chk(yu, ya + STEP_WORD, "y pointer step");
   endtask
   task automatic ptr_chk(input dsa_agu_req_s q, input logic ws,
      input logic [15:0] e);
      @(posedge mclk);
      if (ws)
         w_req <= q;
      else
         xr_req <= q;
      #1;
      chk(ws ? wu : xu, e, "pointer modify");
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk)
      begin
         xr_req.req <= 1'b0;
         yr_req.req <= 1'b0;
         w_req.req <= 1'b0;
         dual <= 1'b0;
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      if (!rst && trap_r === 1'b1)
         n_trap++;
      if (!rst && xv === 1'b1)
      begin
         cur = (xq.size() > 0) ? xq.pop_front() : 17'h1ffff;
         chk(xres, cur.v, "x read data");
         chk({15'h0, trap_r}, {15'h0, cur.t}, "read trap");
      end
      if (!rst && yv === 1'b1)
      begin
         cur.v = (yq.size() > 0) ? yq.pop_front() : 16'hxxxx;
         chk(yres, cur.v, "y data");
      end
   end
   initial
   begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1 chk(xres, 16'h0000, "reset result");
      chk({14'h0, xv, trap_r}, 16'h0000, "reset flags");
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         ra[i] = {4'h5, seed[11:1], 1'b0};
         wr(ra[i], 1'b0, seed[31:16]);
      end
      for (int i = 0; i < 8; i++)
         xrd(ra[i], 1'b0, DSA_LOAD_PLAIN, DSA_MODE_DIRECT);
      wr(16'h0900, 1'b0, 16'h1234);
      wr(16'h0901, 1'b1, 16'h0085);
      wr(16'h0902, 1'b0, 16'h5aa5);
      wr(16'h0903, 1'b0, 16'hdead);
      idle(4);
      for (int k = 0; k < 3; k++)
      begin
         xrd(16'h0901, 1'b1, dsa_ext_e'(k), DSA_MODE_NEAR);
         xrd(16'h0900, 1'b1, dsa_ext_e'(k), DSA_MODE_INDIRECT);
      end
      xrd(16'h0900, 1'b0, DSA_LOAD_PLAIN, DSA_MODE_INDIRECT);
      xrd(16'h0903, 1'b0, DSA_LOAD_PLAIN, DSA_MODE_INDIRECT);
      idle(4);
      $display("test byte lanes and alignment done");
      wr(16'h0022, 1'b0, 16'hc3a5);
      wr(16'h0024, 1'b0, 16'h0f1e);
      wr(16'h0025, 1'b1, 16'h0077);
      xrd(16'h0022, 1'b0, DSA_LOAD_PLAIN, DSA_MODE_NEAR);
      xrd(16'h0025, 1'b1, DSA_LOAD_ZERO, DSA_MODE_DIRECT);
      xrd(16'h0100, 1'b0, DSA_LOAD_PLAIN, DSA_MODE_DIRECT);
      xrd(16'h7800, 1'b0, DSA_LOAD_PLAIN, DSA_MODE_DIRECT);
      xrd(16'h9234, 1'b0, DSA_LOAD_PLAIN, DSA_MODE_DIRECT);
      xrd(16'hf235, 1'b1, DSA_LOAD_SIGN, DSA_MODE_INDIRECT);
      pr = mk(16'h0900, 1'b0, DSA_MODE_INDIRECT);
      pr.req = 1'b0;
      pr.modulo_en = 1'b1;
      pr.mod_start = 16'h08f0;
      pr.mod_end = 16'h0900;
      ptr_chk(pr, 1'b0, 16'h08f0);
      pr.mod_end = 16'h0a00;
      ptr_chk(pr, 1'b0, 16'h0902);
      pr.modulo_en = 1'b0;
      pr.bitrev_en = 1'b1;
      pr.bitrev_mod = 16'h0010;
      pr.source_pointer_reg = 16'h0910;
      ptr_chk(pr, 1'b0, 16'h0912);
      ptr_chk(pr, 1'b1, 16'h0908);
      ydual(ra[0], ra[1], 1'b1);
      ydual(ra[2], ra[3], 1'b0);
      idle(6);
      $display("test regions and dual fetch done");
      chk(16'(n_trap), 16'(n_trap_exp), "trap count");
      chk(16'(xq.size() + yq.size()), 16'h0000, "missing results");
      stop_test();
   end
   initial
   begin
      repeat (5000) @(posedge mclk);
      num_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
